// file: verilog/rtm_retry_timeout_monitor.v
`timescale 1ns/1ps
`include "rtm_defines.vh"
// Functional notes
// - flag set when retried master stays away 2^15 host clocks
// - flags stay set until software writes one; zero writes ignored
// - bit 7 enables host counter, read/write, resets to one
// - bit 6 enables card counter, read/write, resets to one
// - bit 5 shows card target B expiry, resets to zero
// - bit 3 shows card target A expiry, resets to zero
// - bit 1 shows host target expiry, resets to zero
// - bits 4, 2 and 0 always read zero
// - card enable and target A flag reachable only through function 0
module rtm_retry_timeout_monitor (
  input  wire       i_core_clk,     // host clock, 100 MHz
  input  wire       i_rst,          // async reset, active high
  input  wire       i_cfg_wr,       // config write strobe
  input  wire       i_cfg_rd,       // config read strobe
  input  wire       i_cfg_func,     // config function number (0 or 1)
  input  wire [7:0] i_cfg_addr,     // config byte offset
  input  wire [7:0] i_cfg_wdata,    // config write data
  input  wire       i_host_retry,   // host target issued a retry
  input  wire       i_host_return,  // host master returned
  input  wire       i_card_a_retry, // card target A issued a retry
  input  wire       i_card_a_return,// card master A returned
  input  wire       i_card_b_retry, // card target B issued a retry
  input  wire       i_card_b_return,// card master B returned
  output reg  [7:0] o_cfg_rdata,    // config read data, registered
  output reg        o_host_retry_counter_enable, // bit 7 state
  output reg        o_card_retry_counter_enable, // bit 6 state
  output reg        o_host_target_expired,       // bit 1 state
  output reg        o_card_target_a_expired,     // bit 3 state
  output reg        o_card_target_b_expired      // bit 5 state
);

  // channel order used by every per-channel vector below
  localparam CH_HOST   = 0;           // host-side target
  localparam CH_CARD_A = 1;           // card-side target A
  localparam CH_CARD_B = 2;           // card-side target B
  localparam N_CH      = 3;           // number of retry channels

  // access decode
  wire            hit_wr;             // write to the status offset, any function
  wire            hit_rd;             // read of the status offset, any function
  wire            f0_wr;              // write to the status offset through function 0

  // per-channel wiring
  wire [N_CH-1:0] ch_retry;           // retry pulse per channel
  wire [N_CH-1:0] ch_return;          // master came back, per channel
  wire [N_CH-1:0] ch_enable;          // counter enable per channel
  wire [N_CH-1:0] ch_expire;          // one-cycle expiry pulse per channel
  wire [N_CH-1:0] ch_clear;           // write-one-to-clear request per channel
  wire [N_CH-1:0] ch_flag;            // present flag state per channel
  wire [N_CH-1:0] ch_flag_nxt;        // next flag state per channel

  // status bytes as the two functions see them
  wire [7:0]      status;             // function 0 view, every field live
  wire [7:0]      status_f1;          // function 1 view, global fields hidden

  // next values of the registered outputs
  reg             host_en_nxt;        // next host counter enable
  reg             card_en_nxt;        // next card counter enable
  reg  [7:0]      rdata_nxt;          // next read data

  // register decode; the offset alone selects the register
  assign hit_wr = i_cfg_wr && (i_cfg_addr == `RTM_STATUS_OFFSET);
  assign hit_rd = i_cfg_rd && (i_cfg_addr == `RTM_STATUS_OFFSET);

  // global fields only follow writes made through function 0
  assign f0_wr  = hit_wr && !i_cfg_func;

  // gather the per-channel request pulses in channel order
  assign ch_retry  = {i_card_b_retry, i_card_a_retry, i_host_retry};
  assign ch_return = {i_card_b_return, i_card_a_return, i_host_return};

  // both card targets share the card-side enable
  assign ch_enable = {o_card_retry_counter_enable,
                      o_card_retry_counter_enable,
                      o_host_retry_counter_enable};

  // flag state read back in channel order
  assign ch_flag = {o_card_target_b_expired,
                    o_card_target_a_expired,
                    o_host_target_expired};

  // write-one-to-clear; a zero in a flag position leaves the flag alone
  assign ch_clear[CH_HOST]   = hit_wr && i_cfg_wdata[`RTM_HOST_EXP_BIT];
  assign ch_clear[CH_CARD_A] = f0_wr  && i_cfg_wdata[`RTM_CARD_A_EXP_BIT];
  assign ch_clear[CH_CARD_B] = hit_wr && i_cfg_wdata[`RTM_CARD_B_EXP_BIT];

  // one timeout counter and one sticky flag per retried target
  genvar g;
  generate
    for (g = 0; g < N_CH; g = g + 1) begin : g_ch
      // counter restarts on retry, stops on return or disable
      rtm_retry_timer u_timer (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_enable   (ch_enable[g]),
        .i_retry    (ch_retry[g]),
        .i_return   (ch_return[g]),
        .o_expire   (ch_expire[g])
      );

      // an expiry in the clearing cycle wins, so no expiry is ever lost
      assign ch_flag_nxt[g] = ch_expire[g] | (ch_flag[g] & ~ch_clear[g]);
    end
  endgenerate

  // assembled status byte; reserved bits fixed at zero
  assign status = {o_host_retry_counter_enable,
                   o_card_retry_counter_enable,
                   o_card_target_b_expired,
                   1'b0,
                   o_card_target_a_expired,
                   1'b0,
                   o_host_target_expired,
                   1'b0};

  // function 1 does not see the global card enable or the target A flag
  assign status_f1 = {o_host_retry_counter_enable,
                      1'b0,
                      o_card_target_b_expired,
                      1'b0,
                      1'b0,
                      1'b0,
                      o_host_target_expired,
                      1'b0};

  // enable next values; host enable is per socket, card enable global
  always @* begin
    host_en_nxt = o_host_retry_counter_enable;
    card_en_nxt = o_card_retry_counter_enable;
    if (hit_wr) begin
      host_en_nxt = i_cfg_wdata[`RTM_HOST_EN_BIT];
    end
    if (f0_wr) begin
      card_en_nxt = i_cfg_wdata[`RTM_CARD_EN_BIT];
    end
  end

  // read data next value; zero whenever the status register is not read
  always @* begin
    rdata_nxt = 8'h00;
    if (hit_rd) begin
      if (i_cfg_func) begin
        rdata_nxt = status_f1;
      end else begin
        rdata_nxt = status;
      end
    end
  end

  // counter enables; both come out of reset enabled
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_host_retry_counter_enable <= `RTM_HOST_EN_RST;
      o_card_retry_counter_enable <= `RTM_CARD_EN_RST;
    end else begin
      o_host_retry_counter_enable <= host_en_nxt;
      o_card_retry_counter_enable <= card_en_nxt;
    end
  end

  // sticky expiry flags; all clear out of reset
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_host_target_expired   <= `RTM_EXP_RST;
      o_card_target_a_expired <= `RTM_EXP_RST;
      o_card_target_b_expired <= `RTM_EXP_RST;
    end else begin
      o_host_target_expired   <= ch_flag_nxt[CH_HOST];
      o_card_target_a_expired <= ch_flag_nxt[CH_CARD_A];
      o_card_target_b_expired <= ch_flag_nxt[CH_CARD_B];
    end
  end

  // read data register; valid for one cycle after the read strobe
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_cfg_rdata <= 8'h00;
    end else begin
      o_cfg_rdata <= rdata_nxt;
    end
  end

  // a user that wants the flags to keep latching must leave the enables
  // set: clearing an enable also throws away any count in progress, so a
  // retry that was pending at that moment will never be reported
endmodule

// file: verilog/rtm_defines.vh
`ifndef RTM_DEFINES_VH
`define RTM_DEFINES_VH
// configuration offset of the retry status register
`define RTM_STATUS_OFFSET   8'h90
// field positions
`define RTM_HOST_EN_BIT     7
`define RTM_CARD_EN_BIT     6
`define RTM_CARD_B_EXP_BIT  5
`define RTM_CARD_A_EXP_BIT  3
`define RTM_HOST_EXP_BIT    1
// reset values
`define RTM_HOST_EN_RST     1'b1
`define RTM_CARD_EN_RST     1'b1
`define RTM_EXP_RST         1'b0
// timeout of 2^15 host clock cycles
`define RTM_TIMEOUT_CYCLES  16'h8000
`define RTM_CNT_W           16
`endif

// file: verilog/rtm_retry_timer.v
`timescale 1ns/1ps
`include "rtm_defines.vh"
// one retry timeout counter; pulses o_expire once the limit is reached
module rtm_retry_timer (
  input  wire i_core_clk,  // host clock
  input  wire i_rst,       // async reset, active high
  input  wire i_enable,    // counter enable
  input  wire i_retry,     // retry issued to a master (pulse)
  input  wire i_return,    // retried master came back (pulse)
  output reg  o_expire     // one-cycle expiry pulse
);
  reg                     run_r;
  reg [`RTM_CNT_W-1:0]    cnt_r;

  // restart on each retry, stop on return, disable or expiry
  always @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      run_r    <= 1'b0;
      cnt_r    <= {`RTM_CNT_W{1'b0}};
      o_expire <= 1'b0;
    end else begin
      o_expire <= 1'b0;
      if (!i_enable) begin
        run_r <= 1'b0;
        cnt_r <= {`RTM_CNT_W{1'b0}};
      end else if (i_retry) begin
        run_r <= 1'b1;
        cnt_r <= 16'h0001;
      end else if (i_return) begin
        run_r <= 1'b0;
      end else if (run_r) begin
        if (cnt_r == `RTM_TIMEOUT_CYCLES) begin
          run_r    <= 1'b0;
          o_expire <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end
    end
  end
endmodule

// file: testbench/rtm_props.sv
`timescale 1ns/1ps
module rtm_props (
  input wire       i_core_clk, i_rst, i_cfg_wr, i_cfg_rd, i_cfg_func, i_host_retry, i_host_return,
  input wire [7:0] i_cfg_addr, i_cfg_wdata, o_cfg_rdata,
  input wire       o_host_retry_counter_enable, o_card_retry_counter_enable,
  input wire       o_host_target_expired, o_card_target_a_expired, o_card_target_b_expired
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  reg  [16:0] hcnt_r;
  wire        wr90 = i_cfg_wr && i_cfg_addr == 8'h90;
  // cycles since the last host retry, cleared on return or disable
  always @(posedge i_core_clk or posedge i_rst)
    if (i_rst) hcnt_r <= 17'h0;
    else if (i_host_retry) hcnt_r <= 17'h1;
    else if (i_host_return || !o_host_retry_counter_enable) hcnt_r <= 17'h0;
    else if (hcnt_r != 17'h0) hcnt_r <= hcnt_r + 17'h1;
  property p_timeout; $rose(o_host_target_expired) |-> hcnt_r == 17'h8002; endproperty
  a_timeout: assert property (p_timeout) else $error("host expiry off time");
  property p_sticky; o_host_target_expired && !(wr90 && i_cfg_wdata[1]) |=> o_host_target_expired;
  endproperty
  a_sticky: assert property (p_sticky) else $error("host flag dropped");
  property p_hen; wr90 |=> o_host_retry_counter_enable == $past(i_cfg_wdata[7]); endproperty
  a_hen: assert property (p_hen) else $error("host enable not written");
  property p_cen; wr90 && !i_cfg_func |=> o_card_retry_counter_enable == $past(i_cfg_wdata[6]);
  endproperty
  a_cen: assert property (p_cen) else $error("card enable not written");
  property p_rdv; i_cfg_rd && i_cfg_addr == 8'h90 |=> {o_cfg_rdata[7], o_cfg_rdata[5],
    o_cfg_rdata[1]} == $past({o_host_retry_counter_enable, o_card_target_b_expired,
    o_host_target_expired}); endproperty
  a_rdv: assert property (p_rdv) else $error("status read wrong");
  property p_aset; $rose(o_card_target_a_expired) |-> $past(o_card_retry_counter_enable); endproperty
  a_aset: assert property (p_aset) else $error("card A set while off");
  property p_rsvd; i_cfg_rd |=> o_cfg_rdata[4] == 1'b0 && o_cfg_rdata[2] == 1'b0
    && o_cfg_rdata[0] == 1'b0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit high");
  property p_f1; i_cfg_wr && i_cfg_func |=> $stable(o_card_retry_counter_enable); endproperty
  a_f1: assert property (p_f1) else $error("function 1 changed card enable");
  property p_hoff; $rose(o_host_target_expired) |-> $past(o_host_retry_counter_enable); endproperty
  a_hoff: assert property (p_hoff) else $error("host set while off");
  c_host: cover property ($rose(o_host_target_expired));
  c_cardb: cover property ($rose(o_card_target_b_expired));
  c_f1: cover property (wr90 && i_cfg_func);
endmodule
bind rtm_retry_timeout_monitor rtm_props rtm_props_inst (.i_core_clk, .i_rst, .i_cfg_wr,
  .i_cfg_rd, .i_cfg_func, .i_host_retry, .i_host_return, .i_cfg_addr, .i_cfg_wdata, .o_cfg_rdata,
  .o_host_retry_counter_enable, .o_card_retry_counter_enable, .o_host_target_expired,
  .o_card_target_a_expired, .o_card_target_b_expired);

// file: testbench/rtm_master_model.sv
`timescale 1ns/1ps
module rtm_master_model (
  input  wire        i_core_clk, // host clock
  input  wire [2:0]  i_go,       // start retry per master {b, a, host}
  input  wire [15:0] i_delay,    // cycles to come back, 0 = never
  output reg  [2:0]  o_retry,    // retry pulses
  output reg  [2:0]  o_return    // return pulses
);
  reg [15:0] cnt_r = 16'h0;
  reg [2:0]  pend_r = 3'h0;
  initial o_retry = 3'h0;
  initial o_return = 3'h0;
  // masters retried now come back after the delay, or stay away
  always @(posedge i_core_clk) begin
    o_retry <= i_go;
    o_return <= 3'h0;
    if (|i_go) begin
      cnt_r <= i_delay;
      pend_r <= i_go;
    end else if (cnt_r == 16'h1) begin
      o_return <= pend_r;
      cnt_r <= 16'h0;
    end else if (cnt_r != 16'h0) cnt_r <= cnt_r - 16'h1;
  end
endmodule

// file: testbench/rtm_retry_timeout_monitor_tb.sv
`timescale 1ns/1ps
module rtm_retry_timeout_monitor_tb;
  reg        i_core_clk = 1'b0, i_rst = 1'b1, i_cfg_wr = 1'b0, i_cfg_rd = 1'b0, i_cfg_func = 1'b0;
  reg  [7:0] i_cfg_addr = 8'h90, i_cfg_wdata = 8'h0, rd;
  reg  [2:0] go = 3'h0;
  reg [15:0] dly = 16'h0;
  reg [17:0] rows [0:4];
  wire [7:0] o_cfg_rdata;
  wire i_host_retry, i_host_return, i_card_a_retry, i_card_a_return, i_card_b_retry,
    i_card_b_return, o_host_retry_counter_enable, o_card_retry_counter_enable,
    o_host_target_expired, o_card_target_a_expired, o_card_target_b_expired;
  integer n_errors = 0, num_checks = 0, i;
  always #5 i_core_clk = ~i_core_clk;
  rtm_retry_timeout_monitor rtm_retry_timeout_monitor_inst (.i_core_clk, .i_rst, .i_cfg_wr,
    .i_cfg_rd, .i_cfg_func, .i_cfg_addr, .i_cfg_wdata, .i_host_retry, .i_host_return,
    .i_card_a_retry, .i_card_a_return, .i_card_b_retry, .i_card_b_return, .o_cfg_rdata,
    .o_host_retry_counter_enable, .o_card_retry_counter_enable, .o_host_target_expired,
    .o_card_target_a_expired, .o_card_target_b_expired);
  rtm_master_model rtm_master_model_inst (.i_core_clk, .i_go(go), .i_delay(dly),
    .o_retry({i_card_b_retry, i_card_a_retry, i_host_retry}),
    .o_return({i_card_b_return, i_card_a_return, i_host_return}));
  // state outputs laid out like the status byte
  function automatic [7:0] st();
    st = {o_host_retry_counter_enable, o_card_retry_counter_enable, o_card_target_b_expired,
      1'b0, o_card_target_a_expired, 1'b0, o_host_target_expired, 1'b0};
  endfunction
  task chk(input [7:0] got, input [7:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one access from a falling edge; strobes stay up for back-to-back use
  task acc(input f, input w, input [7:0] a, input [7:0] d);
    {i_cfg_func, i_cfg_wr, i_cfg_rd, i_cfg_addr, i_cfg_wdata} = {f, w, !w, a, d};
    @(negedge i_core_clk);
    rd = o_cfg_rdata;
  endtask
  task wrap_up;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // main sequence: rows hold {write func, wdata, read func, expected}
  initial begin
    rows[0] = {1'b0, 8'h08, 1'b0, 8'h00};
    rows[1] = {1'b0, 8'hff, 1'b0, 8'hc0};
    rows[2] = {1'b1, 8'h00, 1'b0, 8'h40};
    rows[3] = {1'b1, 8'hc0, 1'b1, 8'h80};
    rows[4] = {1'b0, 8'h80, 1'b0, 8'h80};
    repeat (12) @(negedge i_core_clk);
    i_rst = 1'b0;
    acc(0, 0, 8'h90, 8'h0);
    chk(rd, 8'hc0);
    {i_cfg_rd, go} = 4'h7;
    @(negedge i_core_clk);
    go = 3'h0;
    repeat (32769) @(negedge i_core_clk);
    chk(st(), 8'hc0);
    @(negedge i_core_clk);
    chk(st(), 8'hea);
    acc(0, 1, 8'h90, 8'hc0);
    acc(0, 0, 8'h90, 8'h0);
    chk(rd, 8'hea);
    acc(1, 1, 8'h90, 8'hea);
    acc(0, 0, 8'h90, 8'h0);
    chk(rd, 8'hc8);
    $display("expiry test done");
    for (i = 0; i < 5; i = i + 1) begin
      acc(rows[i][17], 1, 8'h90, rows[i][16:9]);
      acc(rows[i][8], 0, 8'h90, 8'h0);
      chk(rd, rows[i][7:0]);
    end
    acc(0, 1, 8'h91, 8'hff);
    acc(0, 0, 8'h91, 8'h0);
    chk(rd, 8'h00);
    acc(0, 0, 8'h90, 8'h0);
    chk(rd, 8'h80);
    $display("register test done");
    {i_cfg_rd, go, dly} = {4'h7, 16'd20};
    @(negedge i_core_clk);
    go = 3'h0;
    repeat (32800) @(negedge i_core_clk);
    chk(st(), 8'h80);
    $display("disable and return test done");
    i_rst = 1'b1;
    @(negedge i_core_clk);
    chk(st(), 8'hc0);
    i_rst = 1'b0;
    acc(0, 0, 8'h90, 8'h0);
    chk(rd, 8'hc0);
    $display("mid-run reset test done");
    wrap_up;
  end
endmodule
